// ---- src/evt_if.sv ----
// event detector carrier between controller and pin detector
`timescale 1ns/1ns
interface evt_if;
  logic pin;
  logic polarity;
  logic [3:0] port;
  logic rd_q2;
  logic edge_evt;
  logic port_evt;
  modport det (input pin, polarity, port, rd_q2, output edge_evt, port_evt);
  modport ctl (output pin, polarity, port, rd_q2, input edge_evt, port_evt);
endinterface

// ---- src/irq_ctrl.sv ----
// four-source interrupt controller with register slave
// Summary of operation
// RULE_01 - four sources: edge pin, timer rollover, upper port change, comparator
// RULE_02 - control bit 7 is global enable; clear blocks every vector branch
// RULE_03 - every reset clears the global enable
// RULE_04 - return-from-service instruction sets the global enable
// RULE_05 - acceptance clears global enable, pushes return address, loads vector 0004h
// RULE_06 - external event to vector takes three or four instruction cycles
// RULE_07 - each flag sets on its event regardless of any enable
// RULE_08 - clearing global enable forces a no-op cycle; pending requests stay pending
// RULE_09 - edge pin triggers rising when polarity select is one, else falling
// RULE_10 - edge sets control bit 1; enable at control bit 4 gates it
// RULE_11 - edge pin wakes from sleep only if enabled at sleep entry
// RULE_12 - timer rollover sets control bit 2; enable at bit 5 gates it
// RULE_13 - change on upper port pins sets bit 0; enable at bit 3
// RULE_14 - port change coinciding with a port read at Q2 may be missed
// RULE_15 - comparator sets peripheral flag bit 6, gated by enable and peripheral gate
// RULE_16 - comparator wake leaves flag bit 6 set; other wakes leave it unchanged
// RULE_17 - software clears serviced flags before re-enabling interrupts
// RULE_18 - only the return address is saved on entry
// RULE_19 - wake from sleep with global enable set then branches to vector
// RULE_20 - enabled source wakes sleep regardless of global enable
// RULE_21 - core request: global enable and any enabled flag or gated peripheral
`timescale 1ns/1ns
module irq_ctrl
  import irqc_pkg::*;
(
  input wire logic aclk, // 10 MHz clock
  input wire logic aresetn, // sync reset, low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic external_edge_pin, // edge interrupt pin
  input wire logic edge_polarity_select, // 1 rising, 0 falling
  input wire logic free_timer_rollover, // timer wrap pulse
  input wire logic [3:0] upper_port, // upper port pins
  input wire logic upper_port_read, // core reads port
  input wire logic comparator_change, // comparator event pulse
  input wire logic return_from_service_instr, // return executed
  input wire logic sleep_instr, // sleep executed
  input wire logic [12:0] return_pc, // address to push
  output logic irq_request, // core request level
  output logic vector_load, // load vector pulse
  output logic [12:0] vector_pc, // vector address
  output logic stack_push, // push pulse
  output logic [12:0] stack_push_pc, // pushed address
  output logic insert_nop, // forced no-op cycle
  output logic asleep, // core in sleep
  output logic wake_pulse, // wake from sleep
  output logic [1:0] quarter // instruction phase
);
  logic [1:0] q_r;
  logic [7:0] ctrl_r;
  logic [7:0] pflag_r;
  logic [7:0] pen_r;
  logic edge_en_sleep_r;
  core_state_e state_r;
  logic nop_arm_r;
  logic nop_cyc_r;
  logic irq_req_r;
  logic vload_r;
  logic [12:0] vpc_r;
  logic push_r;
  logic [12:0] push_pc_r;
  logic wake_r;
  logic aw_hold_r;
  logic [11:0] awaddr_r;
  logic w_hold_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] pflag_nxt;

  evt_if ev ();

  pin_event_detect u_det (
    .aclk(aclk),
    .aresetn(aresetn),
    .ev(ev)
  );

  // instruction cycle divider: four quarters, enable on the last
  wire cycle_en = (q_r == Q_LAST);
  assign ev.pin = external_edge_pin;
  assign ev.polarity = edge_polarity_select;
  assign ev.port = upper_port;
  assign ev.rd_q2 = upper_port_read && (q_r == Q_READ);

  // event sources
  wire edge_evt = ev.edge_evt;
  wire port_evt = ev.port_evt;
  wire tmr_evt = free_timer_rollover;
  wire cmp_evt = comparator_change;
  wire [7:0] set_vec = ({7'h00, tmr_evt} << B_TMR_F) // [RULE_01] [RULE_12]
    | ({7'h00, edge_evt} << B_EDGE_F) // [RULE_10]
    | ({7'h00, port_evt} << B_PORT_F); // [RULE_13]

  // register bus decode
  wire wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  wire wr_lane = wstrb_r[0];
  wire wr_ctrl_hit = (awaddr_r == ADDR_CTRL);
  wire wr_pflag_hit = (awaddr_r == ADDR_PFLAG);
  wire wr_pen_hit = (awaddr_r == ADDR_PEN);
  wire wr_hit = wr_ctrl_hit || wr_pflag_hit || wr_pen_hit;
  wire wr_ctrl = wr_fire && wr_ctrl_hit && wr_lane;
  wire wr_pflag = wr_fire && wr_pflag_hit && wr_lane;
  wire wr_pen = wr_fire && wr_pen_hit && wr_lane;
  wire ar_fire = s_axi_arvalid && !rvalid_r;
  wire rd_ctrl_hit = (s_axi_araddr == ADDR_CTRL);
  wire rd_pflag_hit = (s_axi_araddr == ADDR_PFLAG);
  wire rd_pen_hit = (s_axi_araddr == ADDR_PEN);
  wire rd_hit = rd_ctrl_hit || rd_pflag_hit || rd_pen_hit;
  wire [7:0] rd_byte = rd_ctrl_hit ? ctrl_r : rd_pflag_hit ? pflag_r : rd_pen_hit ? pen_r : 8'h00;

  // request and wake conditions
  wire core_src = |(ctrl_r[B_TMR_EN:B_PORT_EN] & ctrl_r[B_TMR_F:B_PORT_F]);
  wire periph_src = |(pflag_r & pen_r & PERIPH_MASK);
  wire irq_req = ctrl_r[B_GIE] && (core_src || (ctrl_r[B_PGATE] && periph_src)); // [RULE_02] [RULE_21]
  wire wake_tmr = ctrl_r[B_TMR_EN] && ctrl_r[B_TMR_F];
  wire wake_port = ctrl_r[B_PORT_EN] && ctrl_r[B_PORT_F];
  wire wake_edge = edge_en_sleep_r && ctrl_r[B_EDGE_EN] && ctrl_r[B_EDGE_F]; // [RULE_11]
  wire wake_periph = ctrl_r[B_PGATE] && periph_src;
  wire wake_any = wake_tmr || wake_port || wake_edge || wake_periph; // [RULE_20]
  wire nop_block = nop_arm_r || nop_cyc_r;
  wire take_start = cycle_en && (state_r == ST_RUN) && irq_req && !nop_block; // [RULE_08]
  wire take_done = cycle_en && (state_r == ST_DUMMY2);
  wire sleep_go = sleep_instr && (state_r == ST_RUN) && !take_start;
  wire wake_go = cycle_en && (state_r == ST_SLEEP) && wake_any;
  wire sw_gie_clr = wr_ctrl && ctrl_r[B_GIE] && !wdata_r[B_GIE];
  wire [7:0] ctrl_base = wr_ctrl ? wdata_r[7:0] : ctrl_r;
  wire gie_nxt = take_start ? 1'b0 // [RULE_05]
    : return_from_service_instr ? 1'b1 // [RULE_04]
    : ctrl_base[B_GIE];

  // hardware set wins over a software clear in the same cycle
  always_comb begin
    ctrl_nxt = ctrl_base | set_vec; // [RULE_07]
    ctrl_nxt[B_GIE] = gie_nxt;
    pflag_nxt = wr_pflag ? (wdata_r[7:0] & PERIPH_MASK) : pflag_r;
    pflag_nxt[B_CMP] = pflag_nxt[B_CMP] || cmp_evt; // [RULE_15] [RULE_16]
  end

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign irq_request = irq_req_r;
  assign vector_load = vload_r;
  assign vector_pc = vpc_r;
  assign stack_push = push_r;
  assign stack_push_pc = push_pc_r;
  assign insert_nop = nop_cyc_r;
  assign asleep = (state_r == ST_SLEEP);
  assign wake_pulse = wake_r;
  assign quarter = q_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= 2'h0;
      ctrl_r <= CTRL_RST; // [RULE_03]
      pflag_r <= PFLAG_RST;
      pen_r <= PEN_RST;
    end else begin
      q_r <= q_r + 2'h1;
      ctrl_r <= ctrl_nxt;
      pflag_r <= pflag_nxt;
      pen_r <= wr_pen ? (wdata_r[7:0] & PERIPH_MASK) : pen_r; // [RULE_15]
    end
  end

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= 12'h000;
      w_hold_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // core sequencing: accept, two dummy cycles, then vector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_RUN;
      edge_en_sleep_r <= 1'b0;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (take_start) begin
            state_r <= ST_DUMMY1; // [RULE_06]
          end else if (sleep_go) begin
            state_r <= ST_SLEEP;
            edge_en_sleep_r <= ctrl_r[B_EDGE_EN]; // [RULE_11]
          end
        end
        ST_SLEEP: begin
          if (wake_go) begin
            state_r <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          // executes the prefetched instruction, then may vector
          if (cycle_en) begin
            state_r <= ST_RUN; // [RULE_19]
          end
        end
        ST_DUMMY1: begin
          if (cycle_en) begin
            state_r <= ST_DUMMY2;
          end
        end
        ST_DUMMY2: begin
          if (cycle_en) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vload_r <= 1'b0;
      vpc_r <= 13'h0000;
      push_r <= 1'b0;
      push_pc_r <= 13'h0000;
      wake_r <= 1'b0;
      irq_req_r <= 1'b0;
    end else begin
      vload_r <= take_done; // [RULE_05]
      push_r <= take_done;
      wake_r <= wake_go; // [RULE_20]
      irq_req_r <= irq_req;
      if (take_done) begin
        vpc_r <= VECTOR_ADDR;
        push_pc_r <= return_pc; // [RULE_18]
      end
    end
  end

  // forced no-op after software clears the global enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nop_arm_r <= 1'b0;
      nop_cyc_r <= 1'b0;
    end else if (cycle_en) begin
      nop_arm_r <= 1'b0;
      nop_cyc_r <= nop_arm_r || sw_gie_clr; // [RULE_08]
    end else if (sw_gie_clr) begin
      nop_arm_r <= 1'b1;
    end
  end

  a_gie_after_reset: assert property (@(posedge aclk) $rose(aresetn) |-> !ctrl_r[B_GIE]) // [RULE_03]
    else $error("global enable set after reset");
  a_return_from_service_instr_sets_gie: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
    return_from_service_instr && !take_start |=> ctrl_r[B_GIE])
    else $error("return did not set global enable");
  a_take_clears_gie: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_05]
    take_start |=> !ctrl_r[B_GIE] ##8 (vload_r && push_r && vpc_r == VECTOR_ADDR))
    else $error("vector entry sequence wrong");
  a_edge_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_10]
    edge_evt |=> ctrl_r[B_EDGE_F])
    else $error("edge flag not set");
  a_timer_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_12]
    tmr_evt |=> ctrl_r[B_TMR_F])
    else $error("timer flag not set");
  a_port_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_13]
    port_evt |=> ctrl_r[B_PORT_F])
    else $error("port flag not set");
  a_cmp_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_15]
    cmp_evt |=> pflag_r[B_CMP])
    else $error("comparator flag not set");
  a_gie_gates_req: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_02]
    !ctrl_r[B_GIE] |-> !irq_req && !take_start)
    else $error("request without global enable");
  a_nop_blocks_take: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_08]
    sw_gie_clr |=> !take_start [*4])
    else $error("interrupt taken in no-op cycle");
  a_wake_from_sleep: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_20]
    wake_go |=> wake_r && state_r == ST_WAKE)
    else $error("no wake from sleep");
  c_take: cover property (@(posedge aclk) disable iff (!aresetn) take_start ##9 vload_r);
  c_wake: cover property (@(posedge aclk) disable iff (!aresetn) wake_go);
  c_nop: cover property (@(posedge aclk) disable iff (!aresetn) nop_cyc_r && irq_req);
endmodule

// ---- src/irqc_pkg.sv ----
// constants for the four-source interrupt controller
package irqc_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [11:0] IDX_CTRL = 12'h00b;
  localparam logic [11:0] IDX_PFLAG = 12'h00c;
  localparam logic [11:0] IDX_PEN = 12'h08c;
  localparam logic [11:0] ADDR_CTRL = {IDX_CTRL[9:0], 2'b00};
  localparam logic [11:0] ADDR_PFLAG = {IDX_PFLAG[9:0], 2'b00};
  localparam logic [11:0] ADDR_PEN = {IDX_PEN[9:0], 2'b00};
  // irq_control bit positions
  localparam int B_GIE = 7;
  localparam int B_PGATE = 6;
  localparam int B_TMR_EN = 5;
  localparam int B_EDGE_EN = 4;
  localparam int B_PORT_EN = 3;
  localparam int B_TMR_F = 2;
  localparam int B_EDGE_F = 1;
  localparam int B_PORT_F = 0;
  // comparator bit in peripheral flag and enable registers
  localparam int B_CMP = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PFLAG_RST = 8'h00;
  localparam logic [7:0] PEN_RST = 8'h00;
  localparam logic [7:0] PERIPH_MASK = 8'h40;
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;
  // quarter phases of one instruction cycle
  localparam logic [1:0] Q_READ = 2'h1;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_WAKE, ST_DUMMY1, ST_DUMMY2} core_state_e;
endpackage

// ---- src/pin_event_detect.sv ----
// edge pin and upper port change detection
`timescale 1ns/1ns
module pin_event_detect
  import irqc_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  evt_if.det ev // pin events
);
  logic pin_prev_r;
  logic [3:0] port_latch_r;
  wire rise = ev.pin && !pin_prev_r;
  wire fall = !ev.pin && pin_prev_r;

  assign ev.edge_evt = ev.polarity ? rise : fall; // [RULE_09]
  // latch follows port on a read; a change at that instant is lost
  assign ev.port_evt = (ev.port != port_latch_r) && !ev.rd_q2; // [RULE_13] [RULE_14]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_r <= ev.pin;
      port_latch_r <= ev.port;
    end else begin
      pin_prev_r <= ev.pin;
      if (ev.rd_q2) begin
        port_latch_r <= ev.port; // [RULE_14]
      end
    end
  end
endmodule

// ---- test/irq_source_model.sv ----
// far-side model: core instruction pulses and interrupt sources
`timescale 1ns/1ns
module irq_source_model (
  input wire logic aclk, // clock
  output logic external_edge_pin, // edge pin level
  output logic edge_polarity_select, // edge polarity
  output logic free_timer_rollover, // timer wrap pulse
  output logic [3:0] upper_port, // port pins
  output logic upper_port_read, // core port read
  output logic comparator_change, // comparator pulse
  output logic return_from_service_instr, // return pulse
  output logic sleep_instr, // sleep pulse
  output logic [12:0] return_pc // address to push
);
  initial begin
    external_edge_pin = 1'b0;
    edge_polarity_select = 1'b0;
    free_timer_rollover = 1'b0;
    upper_port = 4'h0;
    upper_port_read = 1'b0;
    comparator_change = 1'b0;
    return_from_service_instr = 1'b0;
    sleep_instr = 1'b0;
    return_pc = 13'h0123;
  end
  // one-cycle pulse: 0 timer, 1 comparator, 2 return, else sleep
  task pulse(input int sel);
    @(posedge aclk);
    case (sel)
      0: free_timer_rollover <= 1'b1;
      1: comparator_change <= 1'b1;
      2: return_from_service_instr <= 1'b1;
      default: sleep_instr <= 1'b1;
    endcase
    @(posedge aclk);
    free_timer_rollover <= 1'b0;
    comparator_change <= 1'b0;
    return_from_service_instr <= 1'b0;
    sleep_instr <= 1'b0;
  endtask
  task set_pin(input logic v);
    @(posedge aclk);
    external_edge_pin <= v;
  endtask
  task set_pol(input logic v);
    @(posedge aclk);
    edge_polarity_select <= v;
  endtask
  task set_pc(input logic [12:0] v);
    @(posedge aclk);
    return_pc <= v;
  endtask
  task set_port(input logic [3:0] v);
    @(posedge aclk);
    upper_port <= v;
  endtask
  // read held over a whole instruction cycle so the port latch rearms
  task read_port();
    @(posedge aclk);
    upper_port_read <= 1'b1;
    repeat (4) @(posedge aclk);
    upper_port_read <= 1'b0;
  endtask
endmodule

// ---- test/tb.sv ----
// testbench for the four-source interrupt controller
`timescale 1ns/1ns
module tb;
  import irqc_pkg::*;
  logic aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, upper_port;
  logic [1:0] s_axi_bresp, s_axi_rresp, quarter;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic external_edge_pin, edge_polarity_select, free_timer_rollover, upper_port_read;
  logic comparator_change, return_from_service_instr, sleep_instr;
  logic irq_request, vector_load, stack_push, insert_nop, asleep, wake_pulse;
  logic [12:0] return_pc, vector_pc, stack_push_pc;
  int error_cnt = 0;
  int n_compared = 0;

  always #50 aclk = ~aclk;

  irq_ctrl i_irq_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .external_edge_pin, .edge_polarity_select, .free_timer_rollover, .upper_port, .upper_port_read,
    .comparator_change, .return_from_service_instr, .sleep_instr, .return_pc, .irq_request, .vector_load,
    .vector_pc, .stack_push, .stack_push_pc, .insert_nop, .asleep, .wake_pulse, .quarter);

  irq_source_model i_irq_source_model (.aclk, .external_edge_pin, .edge_polarity_select,
    .free_timer_rollover, .upper_port, .upper_port_read, .comparator_change, .return_from_service_instr,
    .sleep_instr, .return_pc);

  task check_data(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task check_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task axi_write(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check_resp("bresp", er, s_axi_bresp);
  endtask

  task axi_read(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check_resp("rresp", er, s_axi_rresp);
    check_data("rdata", {24'h000000, ed}, s_axi_rdata);
  endtask

  // bounded look for an output: 0 vector_load, 1 wake_pulse, 2 insert_nop, else asleep
  task wait_out(input int sel, input int lim, input logic exp, input string nm);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < lim && !hit; n++) begin
      @(posedge aclk);
      #1;
      case (sel)
        0: hit = (vector_load === 1'b1);
        1: hit = (wake_pulse === 1'b1);
        2: hit = (insert_nop === 1'b1);
        default: hit = (asleep === 1'b1);
      endcase
    end
    check_data(nm, {31'h0, exp}, {31'h0, hit});
  endtask

  task print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(ADDR_CTRL, 8'h00, RESP_OKAY);
    axi_read(ADDR_PFLAG, 8'h00, RESP_OKAY);
    axi_read(ADDR_PEN, 8'h00, RESP_OKAY);
    axi_read(12'h000, 8'h00, RESP_SLVERR);
    axi_write(12'h004, 8'hff, RESP_SLVERR);
    axi_write(ADDR_PEN, 8'hff, RESP_OKAY);
    axi_read(ADDR_PEN, PERIPH_MASK, RESP_OKAY);
    // byte lane 0 off: write answered but ignored
    s_axi_wstrb <= 4'he;
    axi_write(ADDR_PEN, 8'h00, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    axi_read(ADDR_PEN, PERIPH_MASK, RESP_OKAY);
    // every source with all control enables off; comparator peripheral enable still set
    i_irq_source_model.pulse(0);
    axi_read(ADDR_CTRL, 8'h04, RESP_OKAY);
    i_irq_source_model.set_pol(1'b1);
    i_irq_source_model.set_pin(1'b1);
    axi_read(ADDR_CTRL, 8'h06, RESP_OKAY);
    i_irq_source_model.set_port(4'h5);
    axi_read(ADDR_CTRL, 8'h07, RESP_OKAY);
    i_irq_source_model.pulse(1);
    axi_read(ADDR_PFLAG, 8'h40, RESP_OKAY);
    check_data("irq_request", 32'h0, {31'h0, irq_request});
    i_irq_source_model.read_port();
    axi_write(ADDR_CTRL, 8'h00, RESP_OKAY);
    axi_write(ADDR_PFLAG, 8'h00, RESP_OKAY);
    axi_read(ADDR_CTRL, 8'h00, RESP_OKAY);
    // with polarity zero only the falling edge counts
    i_irq_source_model.set_pol(1'b0);
    i_irq_source_model.set_pin(1'b0);
    axi_read(ADDR_CTRL, 8'h02, RESP_OKAY);
    axi_write(ADDR_CTRL, 8'h00, RESP_OKAY);
    i_irq_source_model.set_pin(1'b1);
    axi_read(ADDR_CTRL, 8'h00, RESP_OKAY);
    // enabled timer request, global enable off then on
    i_irq_source_model.pulse(0);
    axi_write(ADDR_CTRL, 8'h24, RESP_OKAY);
    wait_out(0, 30, 1'b0, "vector_load");
    axi_write(ADDR_CTRL, 8'ha4, RESP_OKAY);
    wait_out(0, 40, 1'b1, "vector_load");
    check_data("vector_pc", {19'h0, VECTOR_ADDR}, {19'h0, vector_pc});
    check_data("stack_push", 32'h1, {31'h0, stack_push});
    check_data("stack_push_pc", 32'h123, {19'h0, stack_push_pc});
    axi_read(ADDR_CTRL, 8'h24, RESP_OKAY);
    axi_write(ADDR_CTRL, 8'h20, RESP_OKAY);
    i_irq_source_model.pulse(2);
    axi_read(ADDR_CTRL, 8'ha0, RESP_OKAY);
    axi_write(ADDR_CTRL, 8'h20, RESP_OKAY);
    wait_out(2, 12, 1'b1, "insert_nop");
    // sleep with global enable off continues inline
    i_irq_source_model.pulse(3);
    wait_out(3, 8, 1'b1, "asleep");
    i_irq_source_model.pulse(0);
    wait_out(1, 20, 1'b1, "wake_pulse");
    check_data("quarter", 32'h0, {30'h0, quarter});
    wait_out(0, 30, 1'b0, "vector_load");
    axi_read(ADDR_CTRL, 8'h24, RESP_OKAY);
    // sleep with global enable on branches after wake
    i_irq_source_model.set_pc(13'h0456);
    axi_write(ADDR_CTRL, 8'ha0, RESP_OKAY);
    i_irq_source_model.pulse(3);
    wait_out(3, 8, 1'b1, "asleep");
    i_irq_source_model.pulse(0);
    wait_out(1, 20, 1'b1, "wake_pulse");
    check_data("irq_request", 32'h1, {31'h0, irq_request});
    wait_out(0, 40, 1'b1, "vector_load");
    check_data("stack_push_pc", 32'h456, {19'h0, stack_push_pc});
    print_verdict();
  end
endmodule
